// file: tppl_pkg.sv
// tppl_pkg: constants, field layout and helpers for the touch-probe latch.
// assumes one control clock; object dictionary indices are 16-bit.
package tppl_pkg;

	// object dictionary indices
	localparam logic [15:0] OD_IDX_CTRL     = 16'h60B8;
	localparam logic [15:0] OD_IDX_STATUS   = 16'h60B9;
	localparam logic [15:0] OD_IDX_RISE_POS = 16'h60BA;

	localparam int unsigned OD_DATA_W = 32;
	localparam int unsigned POS_WIDTH = 32;
	localparam int unsigned NUM_CH    = 2;
	localparam int unsigned CH_STRIDE = 8;

	// reset values
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [7:0]  CFG_RESET    = 8'h00;

	// control field positions inside one channel byte
	localparam int unsigned CF_EN   = 0;
	localparam int unsigned CF_MODE = 1;
	localparam int unsigned CF_SRC  = 2;
	localparam int unsigned CF_RISE = 4;
	localparam int unsigned CF_FALL = 5;

	// status field positions inside one channel byte
	localparam int unsigned ST_EN   = 0;
	localparam int unsigned ST_RISE = 1;
	localparam int unsigned ST_FALL = 2;
	localparam int unsigned ST_SRC  = 6;
	localparam int unsigned ST_LVL  = 7;

	// trigger source and mode encodings
	localparam logic SRC_GENERAL = 1'b0;
	localparam logic SRC_INDEX   = 1'b1;
	localparam logic MODE_SINGLE = 1'b0;

	typedef enum logic {
		CH_IDLE,
		CH_ARMED
	} tppl_chan_e;

	// one channel's status byte; reserved bits stay zero
	function automatic logic [7:0] tppl_status_byte(
		input logic armed,
		input logic rise,
		input logic fall,
		input logic src,
		input logic lvl
	);
		logic [7:0] b;
		b          = 8'h00;
		b[ST_EN]   = armed;
		b[ST_RISE] = rise;
		b[ST_FALL] = fall;
		b[ST_SRC]  = src;
		b[ST_LVL]  = lvl;
		return b;
	endfunction

endpackage

// file: tppl_sync_edge.sv
// tppl_sync_edge: two-flop synchroniser with edge detection on its output.
// assumes an asynchronous single-bit input and a synchronous active-low reset.
`timescale 1ns/10ps
module tppl_sync_edge (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic prev_q, prev_d;

	always_comb begin
		meta_d = i_pin;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	// one pulse per physical edge, from the second stage only
	assign o_level = sync_q;
	assign o_rise  = sync_q & ~prev_q;
	assign o_fall  = ~sync_q & prev_q;
endmodule

// file: tppl_pos_capture.sv
// tppl_pos_capture: signed position register loaded on a capture pulse.
// assumes the position bus is synchronous to the control clock.
`timescale 1ns/10ps
module tppl_pos_capture #(
	parameter int unsigned W = 32
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_pos,
	output logic      [W-1:0] o_pos
);
	logic [W-1:0] pos_q, pos_d;

	always_comb begin
		pos_d = pos_q;
		if (i_load) begin
			pos_d = i_pos;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pos_q <= '0;
		end else begin
			pos_q <= pos_d;
		end
	end

	assign o_pos = pos_q;
endmodule

// file: tppl_touch_probe_latch.sv
// tppl_touch_probe_latch: two-channel touch-probe position latch.
// assumes object dictionary requests, pins and position are synchronous
// to I_REF_CLK (125 MHz); the trigger pins are resynchronised anyway.
//
// Overview of operation
// - control bit 8 arms probe 2
// - bit 9 selects single or continuous latching
// - settings frozen while enable stays set
// - bits 12/13 enable rising/falling edge latching
// - general input may latch both edges
// - bit 10 picks source; status 14 reports it
// - status word 16 bits, resets to zero
// - status bit 0 shows probe 1 enabled
// - status bit 1 probe 1 rise latched
// - status bit 2 probe 1 fall latched
// - status bit 6 shows probe 1 source
// - status bit 7 shows probe 1 level
// - status bit 8 shows probe 2 enabled
// - status bit 9 probe 2 rise latched
// - status bit 10 probe 2 fall latched
// - status bit 15 shows probe 2 level
// - probe 1 rise captures signed position
// - status bits 3-5, 11-13 read zero
`timescale 1ns/10ps
module tppl_touch_probe_latch #(
	parameter int unsigned POS_W = tppl_pkg::POS_WIDTH
) (
	input  wire logic                           I_REF_CLK,
	input  wire logic                           I_RESETN,
	input  wire logic                           I_PROBE1_GENERAL_INPUT,
	input  wire logic                           I_PROBE2_GENERAL_INPUT,
	input  wire logic                           I_ENC_INDEX,
	input  wire logic [POS_W-1:0]               I_ENC_POSITION,
	input  wire logic [15:0]                    I_OD_INDEX,
	input  wire logic                           I_OD_WR,
	input  wire logic                           I_OD_RD,
	input  wire logic [tppl_pkg::OD_DATA_W-1:0] I_OD_WDATA,
	output logic      [tppl_pkg::OD_DATA_W-1:0] O_OD_RDATA,
	output logic                                O_OD_ACK,
	output logic                                O_OD_ERR,
	output logic      [15:0]                    O_PROBE_STATUS,
	output logic      [POS_W-1:0]               O_PROBE1_RISE_POS
);
	import tppl_pkg::*;

	generate
		if (POS_W < 2 || POS_W > OD_DATA_W) begin : g_bad_width
			$error("POS_W must lie between 2 and the data width");
		end
	endgenerate

	logic [15:0]          ctrl_q, ctrl_d;
	logic [15:0]          status_q, status_d;
	logic [OD_DATA_W-1:0] rdata_q, rdata_d;
	logic                 ack_q, ack_d;
	logic                 err_q, err_d;
	logic [NUM_CH-1:0]    clr_rise;
	logic [NUM_CH-1:0]    clr_fall;
	logic [NUM_CH-1:0]    rise_hit;
	logic [NUM_CH-1:0]    fall_hit;
	logic [NUM_CH-1:0]    gen_in;
	logic [7:0]           ch_status [NUM_CH];
	logic [15:0]          status_live;
	logic [POS_W-1:0]     rise_pos;

	assign gen_in = {I_PROBE2_GENERAL_INPUT, I_PROBE1_GENERAL_INPUT};

	// per-channel probe logic
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic [7:0] ctrl_byte;
			logic       g_lvl, g_rise, g_fall;
			logic       x_lvl, x_rise, x_fall;
			logic       armed, arm, src, lvl, t_rise, t_fall;
			logic       hit_r, hit_f;
			tppl_chan_e state_q, state_d;
			logic [7:0] cfg_q, cfg_d;
			logic       en_prev_q, en_prev_d;
			logic       rflag_q, rflag_d;
			logic       fflag_q, fflag_d;
			logic       rdone_q, rdone_d;
			logic       fdone_q, fdone_d;

			assign ctrl_byte = ctrl_q[ch*CH_STRIDE +: 8];

			tppl_sync_edge u_gen_sync (
				.i_clk   (I_REF_CLK),
				.i_rst_n (I_RESETN),
				.i_pin   (gen_in[ch]),
				.o_level (g_lvl),
				.o_rise  (g_rise),
				.o_fall  (g_fall)
			);

			tppl_sync_edge u_idx_sync (
				.i_clk   (I_REF_CLK),
				.i_rst_n (I_RESETN),
				.i_pin   (I_ENC_INDEX),
				.o_level (x_lvl),
				.o_rise  (x_rise),
				.o_fall  (x_fall)
			);

			assign armed = (state_q == CH_ARMED);
			// arming happens on the rising transition of the enable
			assign arm = ctrl_byte[CF_EN] & ~en_prev_q;
			// frozen copy of the settings while armed
			assign src = armed ? cfg_q[CF_SRC] : ctrl_byte[CF_SRC];
			assign lvl    = (src == SRC_INDEX) ? x_lvl : g_lvl;
			assign t_rise = (src == SRC_INDEX) ? x_rise : g_rise;
			assign t_fall = (src == SRC_INDEX) ? x_fall : g_fall;

			// both edge enables act independently, so both may be set
			assign hit_r = armed & cfg_q[CF_RISE] & t_rise
				& ~(cfg_q[CF_MODE] == MODE_SINGLE & rdone_q);
			assign hit_f = armed & cfg_q[CF_FALL] & t_fall
				& ~(cfg_q[CF_MODE] == MODE_SINGLE & fdone_q);

			always_comb begin
				state_d   = state_q;
				cfg_d     = cfg_q;
				en_prev_d = ctrl_byte[CF_EN];
				rdone_d   = rdone_q | hit_r;
				fdone_d   = fdone_q | hit_f;
				case (state_q)
					CH_IDLE: begin
						if (arm) begin
							state_d = CH_ARMED;
							cfg_d   = ctrl_byte;
							rdone_d = 1'b0;
							fdone_d = 1'b0;
						end
					end
					CH_ARMED: begin
						// clearing the enable stops the probe
						if (!ctrl_byte[CF_EN]) begin
							state_d = CH_IDLE;
						end
					end
					default: begin
						state_d = CH_IDLE;
					end
				endcase
				// a capture in the clearing cycle wins over the clear
				rflag_d = hit_r
					| (rflag_q & ~clr_rise[ch] & ~arm);
				fflag_d = hit_f
					| (fflag_q & ~clr_fall[ch] & ~arm);
			end

			always_ff @(posedge I_REF_CLK) begin
				if (!I_RESETN) begin
					state_q   <= CH_IDLE;
					cfg_q     <= CFG_RESET;
					en_prev_q <= 1'b0;
					rflag_q   <= 1'b0;
					fflag_q   <= 1'b0;
					rdone_q   <= 1'b0;
					fdone_q   <= 1'b0;
				end else begin
					state_q   <= state_d;
					cfg_q     <= cfg_d;
					en_prev_q <= en_prev_d;
					rflag_q   <= rflag_d;
					fflag_q   <= fflag_d;
					rdone_q   <= rdone_d;
					fdone_q   <= fdone_d;
				end
			end

			assign rise_hit[ch] = hit_r;
			assign fall_hit[ch] = hit_f;
			// enable, flags, source and level; reserved bits zero
			assign ch_status[ch] = tppl_status_byte(armed, rflag_q,
				fflag_q, src, lvl);
		end
	endgenerate

	assign status_live = {ch_status[1], ch_status[0]};

	// position loads on the same edge that sets the rise flag
	tppl_pos_capture #(
		.W (POS_W)
	) u_p1_rise_pos (
		.i_clk   (I_REF_CLK),
		.i_rst_n (I_RESETN),
		.i_load  (rise_hit[0]),
		.i_pos   (I_ENC_POSITION),
		.o_pos   (rise_pos)
	);

	// object dictionary access; writes take priority over reads
	always_comb begin
		ctrl_d   = ctrl_q;
		rdata_d  = rdata_q;
		ack_d    = 1'b0;
		err_d    = 1'b0;
		clr_rise = '0;
		clr_fall = '0;
		status_d = status_live;
		if (I_OD_WR) begin
			ack_d = 1'b1;
			case (I_OD_INDEX)
				OD_IDX_CTRL: begin
					ctrl_d = I_OD_WDATA[15:0];
				end
				OD_IDX_STATUS: begin
					// writing zero to a latched flag clears it
					for (int i = 0; i < NUM_CH; i++) begin
						clr_rise[i] = ~I_OD_WDATA[i*CH_STRIDE + ST_RISE];
						clr_fall[i] = ~I_OD_WDATA[i*CH_STRIDE + ST_FALL];
					end
				end
				default: begin
					// read-only position and unknown indices
					err_d = 1'b1;
				end
			endcase
		end else if (I_OD_RD) begin
			ack_d = 1'b1;
			case (I_OD_INDEX)
				OD_IDX_CTRL: begin
					rdata_d = OD_DATA_W'(ctrl_q);
				end
				OD_IDX_STATUS: begin
					rdata_d = OD_DATA_W'(status_live);
				end
				OD_IDX_RISE_POS: begin
					rdata_d = OD_DATA_W'(signed'(rise_pos));
				end
				default: begin
					rdata_d = '0;
					err_d   = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESETN) begin
			ctrl_q   <= CTRL_RESET;
			status_q <= STATUS_RESET;
			rdata_q  <= '0;
			ack_q    <= 1'b0;
			err_q    <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			status_q <= status_d;
			rdata_q  <= rdata_d;
			ack_q    <= ack_d;
			err_q    <= err_d;
		end
	end

	assign O_OD_RDATA        = rdata_q;
	assign O_OD_ACK          = ack_q;
	assign O_OD_ERR          = err_q;
	assign O_PROBE_STATUS    = status_q;
	assign O_PROBE1_RISE_POS = rise_pos;
endmodule

// file: tppl_touch_probe_latch_properties.sv
// tppl_touch_probe_latch_properties: port checks for the probe latch.
// assumes a bind to tppl_touch_probe_latch; one clock, sync reset.
`timescale 1ns/10ps
module tppl_touch_probe_latch_properties
	import tppl_pkg::*;
#(
	parameter int unsigned POS_W = 32
) (
	input  wire logic             I_REF_CLK,
	input  wire logic             I_RESETN,
	input  wire logic             I_PROBE1_GENERAL_INPUT,
	input  wire logic             I_PROBE2_GENERAL_INPUT,
	input  wire logic [15:0]      I_OD_INDEX,
	input  wire logic             I_OD_WR,
	input  wire logic [31:0]      I_OD_WDATA,
	input  wire logic             O_OD_ACK,
	input  wire logic             O_OD_ERR,
	input  wire logic [15:0]      O_PROBE_STATUS,
	input  wire logic [POS_W-1:0] O_PROBE1_RISE_POS
);
	logic wr_ctrl;
	assign wr_ctrl = I_OD_WR && I_OD_INDEX == OD_IDX_CTRL;
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESETN);
	chk_reset_zero: assert property ($rose(I_RESETN) |->
		O_PROBE_STATUS == 16'h0000 && O_PROBE1_RISE_POS == '0)
		else $error("outputs not zero after reset");
	chk_ro_write: assert property (I_OD_WR &&
		I_OD_INDEX == OD_IDX_RISE_POS |=> O_OD_ACK && O_OD_ERR)
		else $error("position write not refused");
	chk_reserved_zero: assert property (O_PROBE_STATUS[5:3] == 3'h0 &&
		O_PROBE_STATUS[13:11] == 3'h0)
		else $error("reserved status bits set");
	chk_p1_en_flag: assert property (wr_ctrl |-> ##3
		O_PROBE_STATUS[0] == $past(I_OD_WDATA[0], 3))
		else $error("probe 1 enable flag wrong");
	chk_p2_en_flag: assert property (wr_ctrl |-> ##3
		O_PROBE_STATUS[8] == $past(I_OD_WDATA[8], 3))
		else $error("probe 2 enable flag wrong");
	chk_p2_src_idle: assert property ((wr_ctrl && !I_OD_WDATA[8])
		##1 (!wr_ctrl) [*2] |=> O_PROBE_STATUS[14] == $past(I_OD_WDATA[10], 3))
		else $error("probe 2 source bit wrong");
	chk_p1_level_high: assert property (
		(!O_PROBE_STATUS[6] && I_PROBE1_GENERAL_INPUT) [*6] |-> O_PROBE_STATUS[7])
		else $error("probe 1 level not shown");
	chk_p2_level_low: assert property (
		(!O_PROBE_STATUS[14] && !I_PROBE2_GENERAL_INPUT) [*6] |->
		!O_PROBE_STATUS[15])
		else $error("probe 2 level not shown");
	chk_p2_rise_cause: assert property (
		$rose(O_PROBE_STATUS[9]) && !O_PROBE_STATUS[14] |->
		$past(I_PROBE2_GENERAL_INPUT, 4) && !$past(I_PROBE2_GENERAL_INPUT, 5))
		else $error("probe 2 rise flag without pin edge");
	chk_pos_with_flag: assert property (
		$changed(O_PROBE1_RISE_POS) |=> O_PROBE_STATUS[1])
		else $error("position changed without flag");
endmodule

// file: tppl_od_master.sv
// tppl_od_master: object dictionary master issuing single requests.
// assumes the latch answers with a one-cycle ack after the taken edge.
`timescale 1ns/10ps
module tppl_od_master (
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic        i_err,
	input  wire logic [31:0] i_rdata,
	output logic      [15:0] o_index,
	output logic             o_wr,
	output logic             o_rd,
	output logic      [31:0] o_wdata
);
	initial begin
		o_index = 16'hFFFF;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 32'hFFFF_FFFF;
	end
	task automatic access(input logic wr, input logic [15:0] idx,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		@(negedge i_clk);
		o_index = idx;
		o_wdata = wd;
		o_wr = wr;
		o_rd = !wr;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_rd = 1'b0;
		// released bus shows the inverse, never the stale request
		o_index = ~idx;
		o_wdata = ~wd;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_ack !== 1'b1 && n < 8);
		// a missing answer leaves unknowns, which every compare refuses
		rd = (i_ack === 1'b1) ? i_rdata : 'x;
		er = (i_ack === 1'b1) ? i_err : 1'bx;
	endtask
endmodule

// file: test_touch_probe_position_latch.sv
// test_touch_probe_position_latch: scenario bench for the probe latch.
// assumes tppl_od_master as host; inputs change on the falling edge.
`timescale 1ns/10ps
module test_touch_probe_position_latch;
	import tppl_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        p1 = 1'b0;
	logic        p2 = 1'b0;
	logic        idx = 1'b0;
	logic [31:0] pos = 32'h0000_0000;
	logic [15:0] od_index;
	logic        od_wr;
	logic        od_rd;
	logic        ack;
	logic        err;
	logic [31:0] od_wdata;
	logic [31:0] rdata;
	logic [31:0] rdat;
	logic        rerr;
	logic [15:0] status;
	logic [31:0] rpos;
	int          miscompares = 0;
	int          compares = 0;
	always #4 clk = ~clk;
	tppl_touch_probe_latch u_dut (.I_REF_CLK(clk), .I_RESETN(rst_n),
		.I_PROBE1_GENERAL_INPUT(p1), .I_PROBE2_GENERAL_INPUT(p2),
		.I_ENC_INDEX(idx), .I_ENC_POSITION(pos), .I_OD_INDEX(od_index),
		.I_OD_WR(od_wr), .I_OD_RD(od_rd), .I_OD_WDATA(od_wdata),
		.O_OD_RDATA(rdata), .O_OD_ACK(ack), .O_OD_ERR(err),
		.O_PROBE_STATUS(status), .O_PROBE1_RISE_POS(rpos));
	tppl_od_master u_mst (.i_clk(clk), .i_ack(ack), .i_err(err),
		.i_rdata(rdata), .o_index(od_index), .o_wr(od_wr), .o_rd(od_rd),
		.o_wdata(od_wdata));
	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cfg(input logic [15:0] d);
		u_mst.access(1'b1, OD_IDX_CTRL, {16'h0000, d}, rdat, rerr);
		check("control write error", 32'h0, {31'h0, rerr});
		repeat (4) @(negedge clk);
	endtask
	task automatic st(input logic [15:0] exp);
		u_mst.access(1'b0, OD_IDX_STATUS, 32'h0, rdat, rerr);
		check("status read error", 32'h0, {31'h0, rerr});
		check("status read", {16'h0000, exp}, rdat);
		check("status port", {16'h0000, exp}, {16'h0000, status});
	endtask
	task automatic ps(input logic [31:0] exp);
		u_mst.access(1'b0, OD_IDX_RISE_POS, 32'h0, rdat, rerr);
		check("position read error", 32'h0, {31'h0, rerr});
		check("position read", exp, rdat);
		check("position port", exp, rpos);
	endtask
	task automatic pulse(input int w);
		for (int k = 0; k < 2; k++) begin
			@(negedge clk);
			case (w)
				1: p1 = ~p1;
				2: p2 = ~p2;
				default: idx = ~idx;
			endcase
			repeat (3) @(negedge clk);
		end
		repeat (6) @(negedge clk);
	endtask
	task automatic t_access();
		st(16'h0000);
		ps(32'h0000_0000);
		u_mst.access(1'b1, OD_IDX_RISE_POS, 32'h1, rdat, rerr);
		check("position write refused", 32'h1, {31'h0, rerr});
		ps(32'h0000_0000);
		u_mst.access(1'b0, 16'h6000, 32'h0, rdat, rerr);
		check("unmapped read", 32'h1, {rdat[30:0], rerr});
	endtask
	task automatic t_probe1();
		@(negedge clk);
		pos = 32'h8000_0005;
		cfg(16'h0011);
		st(16'h0001);
		pulse(1);
		ps(32'h8000_0005);
		st(16'h0003);
		@(negedge clk);
		pos = 32'h0000_1234;
		pulse(1);
		ps(32'h8000_0005);
		cfg(16'h0000);
		cfg(16'h0033);
		pulse(1);
		ps(32'h0000_1234);
		st(16'h0007);
		@(negedge clk);
		pos = 32'h0000_0055;
		p1 = 1'b1;
		repeat (8) @(negedge clk);
		st(16'h0087);
		ps(32'h0000_0055);
		@(negedge clk);
		p1 = 1'b0;
		repeat (8) @(negedge clk);
	endtask
	task automatic t_probe2();
		cfg(16'h3100);
		pulse(2);
		st(16'h0706);
		cfg(16'h3500);
		st(16'h0706);
		cfg(16'h0404);
		st(16'h4646);
		cfg(16'h1704);
		pulse(3);
		st(16'h4346);
		u_mst.access(1'b1, OD_IDX_STATUS, 32'h0, rdat, rerr);
		check("status write error", 32'h0, {31'h0, rerr});
		st(16'h4140);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_access();
		t_probe1();
		t_probe2();
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule
bind tppl_touch_probe_latch tppl_touch_probe_latch_properties #(
	.POS_W(POS_W)) u_chk (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN),
	.I_PROBE1_GENERAL_INPUT(I_PROBE1_GENERAL_INPUT),
	.I_PROBE2_GENERAL_INPUT(I_PROBE2_GENERAL_INPUT),
	.I_OD_INDEX(I_OD_INDEX), .I_OD_WR(I_OD_WR), .I_OD_WDATA(I_OD_WDATA),
	.O_OD_ACK(O_OD_ACK), .O_OD_ERR(O_OD_ERR),
	.O_PROBE_STATUS(O_PROBE_STATUS), .O_PROBE1_RISE_POS(O_PROBE1_RISE_POS));
